// ==== design/rtc_calibration_alarm_core.sv ====
//------------------------------------------------------------
// Purpose: Timekeeping, calibration, alarm and output pin core
// Assumes: A serial protocol engine feeds byte level strobes
// Notes: All state sits in one struct, registered once
//------------------------------------------------------------
// How it works
// RL1: Power failure sets freeze bit, user copy frozen
// RL2: Copying resumes once master clears freeze bit
// RL3: Twenty registers; user copies refreshed together
// RL4: Time register write resets divider chain
// RL5: Clock-range access suspends transfer until stop; here only while the pointer stays at 0-7
// RL6: Time and alarm BCD, others binary
// RL7: Calibration adds/removes pulses at divide-by-256
// RL8: Control bits 4:0 magnitude, bit5 sign
// RL9: 64 minute cycle, -128 or +256 cycles
// RL10: Magnitude N corrects first 2N minutes
// RL11: Pin toggles 512 Hz in frequency test
// RL12: Test output taken before calibration adjustment
// RL13: Power-down clears frequency test bit
// RL14: Pin is open drain, never driven high
// RL15: Alarm match sets flag, may pull pin
// RL16: Repeat bits select matched time fields
// RL17: Undefined repeat codes act once per second
// RL18: Pointer on flags defers alarm event
// RL19: Flags read releases pin, second read shows
// RL20: On battery, pin needs backup and irq enables
// RL21: Flag bits read-only to the master
// RL22: Control bits at their documented positions
// RL23: Halt bit stops oscillator, clear restarts it
// RL24: Century flag toggles on rollover when enabled
// RL25: Pointer advances only on acknowledge clock
// RL26: Otherwise pin follows output level bit
// RL27: Alarm compared once per seconds update
`timescale 1ns/1ps

module rtc_calibration_alarm_core (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_osc_32k,
  input wire logic i_power_fail,
  input wire logic i_on_battery,
  input wire logic i_bus_start,
  input wire logic i_bus_stop,
  input wire logic i_ptr_load,
  input wire logic [7:0] i_ptr_value,
  input wire logic i_wr_strobe,
  input wire logic [7:0] i_wr_data,
  input wire logic i_byte_ack,
  input wire logic i_reading,
  input wire logic i_watchdog_expired,
  input wire logic i_sqw_level,
  input wire logic i_irq_pin_in,
  output logic [7:0] o_rd_data,
  output logic [7:0] o_ptr,
  output logic o_irq_pin_out,
  output logic o_irq_pin_oe
);

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  typedef struct packed {
    logic [2:0] osc_sync;
    logic [2:0] pf_sync;
    logic [2:0] bat_sync;
    logic osc_lvl;
    logic pf_lvl;
    logic bat_lvl;
    logic [15:0] presc;
    logic [5:0] ft_div;
    logic [5:0] cal_min;
    logic [7:0][7:0] tm;
    logic [19:0][7:0] regs;
    logic bus_active;
    logic [7:0] ptr;
    logic alarm_pend;
    logic irq_active;
    logic [7:0] rd_data;
    logic pin_low;
    logic pin_seen;
  } state_t;

  state_t st;
  state_t next_st;

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  // BCD increment with wrap; top bit is the carry
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
    if (v >= hi) bcd_step = {1'b1, lo};
    else if (v[3:0] == 4'h9) bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
    else bcd_step = {1'b0, v + 8'h01};
  endfunction

  // Last day of a BCD month, leap years by BCD year
  function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (m == 8'h02) month_days = leap ? 8'h29 : 8'h28;
    else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) month_days = 8'h30;
    else month_days = 8'h31;
  endfunction

  // ----------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------
  logic osc_halt;
  logic freq_test;
  logic pin_level;
  logic cal_sign;
  logic [4:0] cal_mag;
  logic alarm_irq_en;
  logic sqw_enable;
  logic alarm_backup_en;
  logic freeze;
  logic [4:0] repeat_bits;
  logic wdog_nonzero;
  logic osc_rise;
  logic pf_rise;
  logic cal_active;
  logic [15:0] second_end;
  logic second_tick;
  logic xfer_hold;
  logic [22:0] frac_prod;
  logic [7:0] frac_bin;
  logic [7:0] frac_bcd;
  logic [7:0] next_ptr;
  logic flags_read;

  // Control fields in their register positions
  always_comb begin
    osc_halt = st.regs[rtc_core_pkg::SECONDS_WITH_OSC_HALT][rtc_core_pkg::OSC_HALT_POS]; // RL22
    freq_test = st.regs[rtc_core_pkg::CONTROL_CALIBRATION][rtc_core_pkg::FREQ_TEST_POS]; // RL22
    pin_level = st.regs[rtc_core_pkg::CONTROL_CALIBRATION][rtc_core_pkg::PIN_LEVEL_POS];
    cal_sign = st.regs[rtc_core_pkg::CONTROL_CALIBRATION][rtc_core_pkg::CAL_SIGN_POS]; // RL8
    cal_mag = st.regs[rtc_core_pkg::CONTROL_CALIBRATION][rtc_core_pkg::CAL_MAG_MSB:0]; // RL8
    alarm_irq_en = st.regs[rtc_core_pkg::ALARM_MONTH_ENABLES][rtc_core_pkg::ALARM_IRQ_EN_POS]; // RL22
    sqw_enable = st.regs[rtc_core_pkg::ALARM_MONTH_ENABLES][rtc_core_pkg::SQW_ENABLE_POS]; // RL22
    alarm_backup_en = st.regs[rtc_core_pkg::ALARM_MONTH_ENABLES][rtc_core_pkg::ALARM_BACKUP_EN_POS];
    freeze = st.regs[rtc_core_pkg::ALARM_HOUR][rtc_core_pkg::FREEZE_POS];
    repeat_bits = {st.regs[rtc_core_pkg::ALARM_DATE][rtc_core_pkg::REPEAT5_POS],
                   st.regs[rtc_core_pkg::ALARM_DATE][rtc_core_pkg::REPEAT_POS],
                   st.regs[rtc_core_pkg::ALARM_HOUR][rtc_core_pkg::REPEAT_POS],
                   st.regs[rtc_core_pkg::ALARM_MINUTES][rtc_core_pkg::REPEAT_POS],
                   st.regs[rtc_core_pkg::ALARM_SECONDS][rtc_core_pkg::REPEAT_POS]};
    wdog_nonzero = st.regs[rtc_core_pkg::WATCHDOG_TIMEOUT] != 8'h00;
  end

  // Filtered pin edges: second and third stages must agree
  assign osc_rise = (st.osc_sync[1] == st.osc_sync[2]) && st.osc_sync[2] && !st.osc_lvl;
  assign pf_rise = (st.pf_sync[1] == st.pf_sync[2]) && st.pf_sync[2] && !st.pf_lvl;

  // Corrected second length for this second
  always_comb begin
    cal_active = ({1'b0, st.cal_min} < {1'b0, cal_mag, 1'b0}) && (cal_mag != 5'd0) // RL10
                 && (st.tm[rtc_core_pkg::SECONDS_WITH_OSC_HALT][6:0] == 7'h00); // RL9
    if (!cal_active) second_end = rtc_core_pkg::TICKS_PER_SECOND;
    else if (cal_sign) second_end = rtc_core_pkg::TICKS_PER_SECOND - rtc_core_pkg::CAL_SHORTEN; // RL7
    else second_end = rtc_core_pkg::TICKS_PER_SECOND + rtc_core_pkg::CAL_LENGTHEN; // RL7
  end

  // Halted oscillator produces no ticks
  assign second_tick = osc_rise && !osc_halt && (st.presc + 16'd1 >= second_end); // RL23

  // Clock-range access holds the user copy steady
  assign xfer_hold = st.bus_active && (st.ptr <= rtc_core_pkg::LAST_TIME_REG); // RL5

  // Hundredths of a second from the divider phase
  always_comb begin
    frac_prod = 23'(st.presc) * 23'd100;
    frac_bin = (frac_prod[22:15] > 8'd99) ? 8'd99 : frac_prod[22:15];
    frac_bcd = {4'(frac_bin / 8'd10), 4'(frac_bin % 8'd10)}; // RL6
  end

  // Pointer advance with wrap past the last register
  assign next_ptr = (st.ptr >= rtc_core_pkg::SQUARE_WAVE_RATE) ? 8'h00 : st.ptr + 8'h01;
  assign flags_read = i_byte_ack && i_reading && (st.ptr == rtc_core_pkg::EVENT_FLAGS);

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  always_comb begin
    logic [8:0] s;
    logic [8:0] mi;
    logic [8:0] h;
    logic [8:0] dw;
    logic [8:0] dt;
    logic [8:0] mo;
    logic [8:0] yr;
    logic m_sec;
    logic m_min;
    logic m_hour;
    logic m_date;
    logic m_mon;
    logic match;
    s = '0;
    mi = '0;
    h = '0;
    dw = '0;
    dt = '0;
    mo = '0;
    yr = '0;
    m_sec = 1'b0;
    m_min = 1'b0;
    m_hour = 1'b0;
    m_date = 1'b0;
    m_mon = 1'b0;
    match = 1'b0;
    next_st = st;

    // Input synchronisers and filtered levels
    next_st.osc_sync = {st.osc_sync[1:0], i_osc_32k};
    next_st.pf_sync = {st.pf_sync[1:0], i_power_fail};
    next_st.bat_sync = {st.bat_sync[1:0], i_on_battery};
    if (st.osc_sync[1] == st.osc_sync[2]) next_st.osc_lvl = st.osc_sync[2];
    if (st.pf_sync[1] == st.pf_sync[2]) next_st.pf_lvl = st.pf_sync[2];
    if (st.bat_sync[1] == st.bat_sync[2]) next_st.bat_lvl = st.bat_sync[2];

    // Free test divider, ahead of any calibration
    if (osc_rise) next_st.ft_div = st.ft_div + 6'd1; // RL12

    // Divider chain with calibrated second length
    if (osc_rise && !osc_halt) begin // RL23
      next_st.presc = second_tick ? 16'd0 : st.presc + 16'd1; // RL7
    end

    // Calendar counters on each second
    if (second_tick) begin
      s = bcd_step({1'b0, st.tm[1][6:0]}, 8'h00, 8'h59); // RL6
      next_st.tm[1][6:0] = s[6:0];
      if (s[8]) begin
        mi = bcd_step(st.tm[2], 8'h00, 8'h59);
        next_st.tm[2] = mi[7:0];
        next_st.cal_min = st.cal_min + 6'd1; // RL9
      end
      if (s[8] && mi[8]) begin
        h = bcd_step({2'b00, st.tm[3][5:0]}, 8'h00, 8'h23);
        next_st.tm[3][5:0] = h[5:0];
      end
      if (s[8] && mi[8] && h[8]) begin
        dw = bcd_step(st.tm[4], 8'h01, 8'h07);
        next_st.tm[4] = dw[7:0];
        dt = bcd_step(st.tm[5], 8'h01, month_days(st.tm[6], st.tm[7]));
        next_st.tm[5] = dt[7:0];
      end
      if (s[8] && mi[8] && h[8] && dt[8]) begin
        mo = bcd_step(st.tm[6], 8'h01, 8'h12);
        next_st.tm[6] = mo[7:0];
      end
      if (s[8] && mi[8] && h[8] && dt[8] && mo[8]) begin
        yr = bcd_step(st.tm[7], 8'h00, 8'h99);
        next_st.tm[7] = yr[7:0];
        if (yr[8] && st.tm[3][rtc_core_pkg::CENTURY_ENABLE_POS]) begin
          next_st.tm[3][rtc_core_pkg::CENTURY_FLAG_POS] = !st.tm[3][rtc_core_pkg::CENTURY_FLAG_POS]; // RL24
        end
      end

      // Alarm compare on the new time, once per second
      m_sec = next_st.tm[1][6:0] == st.regs[rtc_core_pkg::ALARM_SECONDS][6:0]; // RL27
      m_min = next_st.tm[2][6:0] == st.regs[rtc_core_pkg::ALARM_MINUTES][6:0];
      m_hour = next_st.tm[3][5:0] == st.regs[rtc_core_pkg::ALARM_HOUR][5:0];
      m_date = next_st.tm[5][5:0] == st.regs[rtc_core_pkg::ALARM_DATE][5:0];
      m_mon = next_st.tm[6][4:0] == st.regs[rtc_core_pkg::ALARM_MONTH_ENABLES][4:0];
      case (repeat_bits) // RL16
        5'b11110: match = m_sec;
        5'b11100: match = m_sec && m_min;
        5'b11000: match = m_sec && m_min && m_hour;
        5'b10000: match = m_sec && m_min && m_hour && m_date;
        5'b00000: match = m_sec && m_min && m_hour && m_date && m_mon;
        default: match = 1'b1; // RL17
      endcase
    end

    // Bus session tracking and pointer
    if (i_bus_start) next_st.bus_active = 1'b1;
    if (i_bus_stop) next_st.bus_active = 1'b0; // RL5
    if (i_ptr_load) next_st.ptr = i_ptr_value;
    else if (i_byte_ack) next_st.ptr = next_ptr; // RL25

    // Simultaneous refresh of all user time copies
    if (!freeze && !xfer_hold) begin // RL1 RL2 RL5
      for (int i = 1; i <= 7; i++) begin
        next_st.regs[i] = next_st.tm[i]; // RL3
      end
      next_st.regs[rtc_core_pkg::FRACTION_SECONDS] = frac_bcd;
    end

    // Master writes; time writes reach both copies
    if (i_wr_strobe && (st.ptr <= rtc_core_pkg::SQUARE_WAVE_RATE)) begin
      next_st.regs[st.ptr[4:0]] = (st.regs[st.ptr[4:0]] & ~rtc_core_pkg::wr_mask(st.ptr))
                                  | (i_wr_data & rtc_core_pkg::wr_mask(st.ptr)); // RL21
      if (st.ptr <= rtc_core_pkg::LAST_TIME_REG) begin
        next_st.tm[st.ptr[2:0]] = i_wr_data & rtc_core_pkg::wr_mask(st.ptr);
        next_st.presc = 16'd0; // RL4
      end
    end

    // Flags read releases pin and clears flags
    if (flags_read) begin
      next_st.irq_active = 1'b0; // RL19
      next_st.regs[rtc_core_pkg::EVENT_FLAGS] = 8'h00; // RL19
    end

    // Watchdog event from the timer block; set wins
    if (i_watchdog_expired) next_st.regs[rtc_core_pkg::EVENT_FLAGS][rtc_core_pkg::WDOG_FLAG_POS] = 1'b1;

    // Alarm event deferred while pointer rests on flags
    if (match) next_st.alarm_pend = 1'b1;
    if ((match || st.alarm_pend) && (st.ptr != rtc_core_pkg::EVENT_FLAGS)) begin // RL18
      next_st.alarm_pend = 1'b0;
      next_st.regs[rtc_core_pkg::EVENT_FLAGS][rtc_core_pkg::ALARM_FLAG_POS] = 1'b1; // RL15
      next_st.irq_active = 1'b1;
    end

    // Power failure: freeze user copy, drop test mode
    if (pf_rise) begin
      next_st.regs[rtc_core_pkg::ALARM_HOUR][rtc_core_pkg::FREEZE_POS] = 1'b1; // RL1
      next_st.regs[rtc_core_pkg::CONTROL_CALIBRATION][rtc_core_pkg::FREQ_TEST_POS] = 1'b0; // RL13
      next_st.regs[rtc_core_pkg::WATCHDOG_TIMEOUT] = 8'h00;
    end

    // Output pin source selection
    if (st.bat_lvl) next_st.pin_low = st.irq_active && alarm_backup_en && alarm_irq_en; // RL20
    else if (sqw_enable) next_st.pin_low = !i_sqw_level;
    else if (alarm_irq_en) next_st.pin_low = st.irq_active; // RL15
    else if (wdog_nonzero) next_st.pin_low = st.regs[rtc_core_pkg::EVENT_FLAGS][rtc_core_pkg::WDOG_FLAG_POS];
    else if (freq_test) next_st.pin_low = !osc_halt && !st.ft_div[rtc_core_pkg::FT_BIT]; // RL11
    else next_st.pin_low = !pin_level; // RL26

    // Read data at the current pointer
    next_st.rd_data = (st.ptr > rtc_core_pkg::SQUARE_WAVE_RATE) ? 8'h00 : st.regs[st.ptr[4:0]];
    next_st.pin_seen = i_irq_pin_in;
  end

  // ----------------------------------------------------------
  // State register
  // ----------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.tm[1] <= rtc_core_pkg::SECONDS_RESET;
      st.tm[4] <= rtc_core_pkg::CALENDAR_RESET;
      st.tm[5] <= rtc_core_pkg::CALENDAR_RESET;
      st.tm[6] <= rtc_core_pkg::CALENDAR_RESET;
      st.regs[1] <= rtc_core_pkg::SECONDS_RESET;
      st.regs[4] <= rtc_core_pkg::CALENDAR_RESET;
      st.regs[5] <= rtc_core_pkg::CALENDAR_RESET;
      st.regs[6] <= rtc_core_pkg::CALENDAR_RESET;
      st.regs[8] <= rtc_core_pkg::CONTROL_RESET;
      st.regs[12] <= rtc_core_pkg::ALARM_HOUR_RESET;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  // Open drain: only ever pulls low
  assign o_irq_pin_out = 1'b0; // RL14
  assign o_irq_pin_oe = st.pin_low; // RL14
  assign o_rd_data = st.rd_data;
  assign o_ptr = st.ptr;

endmodule // rtc_calibration_alarm_core

// ==== design/rtc_core_pkg.sv ====
//------------------------------------------------------------
// Purpose: Shared constants for the timekeeping core
// Assumes: 32,768 Hz time base, 20 byte register map
// Notes: Offsets are byte addresses of the serial pointer
//------------------------------------------------------------
package rtc_core_pkg;

  // ----------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------
  localparam logic [7:0] FRACTION_SECONDS = 8'h00;
  localparam logic [7:0] SECONDS_WITH_OSC_HALT = 8'h01;
  localparam logic [7:0] MINUTES = 8'h02;
  localparam logic [7:0] CENTURY_AND_HOURS = 8'h03;
  localparam logic [7:0] DAY_OF_WEEK = 8'h04;
  localparam logic [7:0] DAY_OF_MONTH = 8'h05;
  localparam logic [7:0] MONTH = 8'h06;
  localparam logic [7:0] YEAR = 8'h07;
  localparam logic [7:0] CONTROL_CALIBRATION = 8'h08;
  localparam logic [7:0] WATCHDOG_TIMEOUT = 8'h09;
  localparam logic [7:0] ALARM_MONTH_ENABLES = 8'h0a;
  localparam logic [7:0] ALARM_DATE = 8'h0b;
  localparam logic [7:0] ALARM_HOUR = 8'h0c;
  localparam logic [7:0] ALARM_MINUTES = 8'h0d;
  localparam logic [7:0] ALARM_SECONDS = 8'h0e;
  localparam logic [7:0] EVENT_FLAGS = 8'h0f;
  localparam logic [7:0] RESERVED_A = 8'h10;
  localparam logic [7:0] RESERVED_C = 8'h12;
  localparam logic [7:0] SQUARE_WAVE_RATE = 8'h13;
  localparam logic [7:0] LAST_TIME_REG = 8'h07;

  // ----------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------
  localparam int OSC_HALT_POS = 7;        // In seconds register
  localparam int CENTURY_ENABLE_POS = 7;  // In century/hours
  localparam int CENTURY_FLAG_POS = 6;
  localparam int PIN_LEVEL_POS = 7;       // In control register
  localparam int FREQ_TEST_POS = 6;
  localparam int CAL_SIGN_POS = 5;
  localparam int CAL_MAG_MSB = 4;
  localparam int ALARM_IRQ_EN_POS = 7;    // In alarm month
  localparam int SQW_ENABLE_POS = 6;
  localparam int ALARM_BACKUP_EN_POS = 5;
  localparam int FREEZE_POS = 6;          // In alarm hour
  localparam int REPEAT_POS = 7;          // In alarm date..seconds
  localparam int REPEAT5_POS = 6;         // In alarm date
  localparam int WDOG_FLAG_POS = 7;       // In flags
  localparam int ALARM_FLAG_POS = 6;

  // ----------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------
  localparam logic [7:0] SECONDS_RESET = 8'h80;
  localparam logic [7:0] CONTROL_RESET = 8'h80;
  localparam logic [7:0] ALARM_HOUR_RESET = 8'h40;
  localparam logic [7:0] CALENDAR_RESET = 8'h01;

  // ----------------------------------------------------------
  // Time base and calibration
  // ----------------------------------------------------------
  localparam int OSC_HZ = 32768;
  localparam int FREQ_TEST_HZ = 512;
  localparam int FT_HALF_TICKS = OSC_HZ / (2 * FREQ_TEST_HZ);
  localparam int FT_BIT = $clog2(FT_HALF_TICKS);
  localparam logic [15:0] TICKS_PER_SECOND = 16'(OSC_HZ);
  localparam logic [15:0] CAL_SHORTEN = 16'd128;
  localparam logic [15:0] CAL_LENGTHEN = 16'd256;

  // Writable bits of each register
  function automatic logic [7:0] wr_mask(input logic [7:0] a);
    if (a == FRACTION_SECONDS) wr_mask = 8'h00;
    else if (a == MINUTES) wr_mask = 8'h7f;
    else if (a == DAY_OF_WEEK) wr_mask = 8'h07;
    else if (a == DAY_OF_MONTH) wr_mask = 8'h3f;
    else if (a == MONTH) wr_mask = 8'h1f;
    else if (a == WATCHDOG_TIMEOUT) wr_mask = 8'h7f;
    else if (a == SQUARE_WAVE_RATE) wr_mask = 8'hf0;
    else if (a >= EVENT_FLAGS) wr_mask = 8'h00;
    else wr_mask = 8'hff;
  endfunction

endpackage

// ==== verification/rtc_core_sva.sv ====
//------------------------------------------------------------
// Purpose: Port level checks of the timekeeping core
// Assumes: Single clock domain, asynchronous reset
// Notes: Attached by the bind at the foot of this file
//------------------------------------------------------------
`timescale 1ns/1ps

module rtc_core_sva (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_ptr_load,
  input wire logic [7:0] i_ptr_value,
  input wire logic i_byte_ack,
  input wire logic [7:0] o_rd_data,
  input wire logic [7:0] o_ptr,
  input wire logic o_irq_pin_out
);
  default clocking core_clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_pin_low;
    o_irq_pin_out == 1'b0;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("shared pin driven high");
  property p_ptr_load;
    i_ce && i_ptr_load |=> o_ptr == $past(i_ptr_value);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");
  property p_ptr_step;
    i_ce && i_byte_ack && !i_ptr_load |=> o_ptr == (($past(o_ptr) >= 8'h13) ? 8'h00 : $past(o_ptr) + 8'h01);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer step wrong");
  property p_ptr_rest;
    !i_byte_ack && !i_ptr_load |=> $stable(o_ptr);
  endproperty
  a_ptr_rest: assert property (p_ptr_rest) else $error("pointer moved without ack");
  property p_unmapped;
    o_ptr > 8'h13 |=> o_rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reserved;
    o_ptr inside {8'h10, 8'h11, 8'h12} |=> o_rd_data == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved read not zero");
  property p_flags_unused;
    o_ptr == 8'h0f |=> o_rd_data[5:0] == 6'h00;
  endproperty
  a_flags_unused: assert property (p_flags_unused) else $error("flags low bits set");
  property p_time_digit;
    o_ptr <= 8'h07 |=> o_rd_data[3:0] <= 4'h9;
  endproperty
  a_time_digit: assert property (p_time_digit) else $error("time digit not decimal");

  // Main scenarios reached
  c_flags_read: cover property (i_byte_ack && o_ptr == 8'h0f);
  c_unmapped: cover property (o_ptr > 8'h13);
  c_control_load: cover property (i_ptr_load && i_ptr_value == 8'h08);
endmodule // rtc_core_sva

bind rtc_calibration_alarm_core rtc_core_sva i_sva (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
  .i_ptr_load(i_ptr_load), .i_ptr_value(i_ptr_value), .i_byte_ack(i_byte_ack), .o_rd_data(o_rd_data),
  .o_ptr(o_ptr), .o_irq_pin_out(o_irq_pin_out));

// ==== verification/rtc_bus_master_model.sv ====
//------------------------------------------------------------
// Purpose: Byte level bus master model for the register port
// Assumes: Outputs change on falling clock edges only
// Notes: Idle data lines carry the inverse of the last byte
//------------------------------------------------------------
`timescale 1ns/1ps

module rtc_bus_master_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rd_data,
  output logic o_bus_start,
  output logic o_bus_stop,
  output logic o_ptr_load,
  output logic [7:0] o_ptr_value,
  output logic o_wr_strobe,
  output logic [7:0] o_wr_data,
  output logic o_byte_ack,
  output logic o_reading
);
  // Bus idle at time zero
  initial begin
    {o_bus_start, o_bus_stop, o_ptr_load, o_wr_strobe, o_byte_ack, o_reading} = 6'h00;
    o_ptr_value = 8'h00;
    o_wr_data = 8'h00;
  end

  // Start, word address, one clock for read data to settle
  task automatic open_at(input logic [7:0] a, input logic rd);
    @(negedge i_clk) o_bus_start = 1'b1;
    @(negedge i_clk) o_bus_start = 1'b0;
    o_reading = rd;
    o_ptr_load = 1'b1;
    o_ptr_value = a;
    @(negedge i_clk) o_ptr_load = 1'b0;
    o_ptr_value = ~a;
    @(negedge i_clk);
  endtask

  // Data byte with acknowledge clock, then stop
  task automatic byte_close(input logic wr, input logic [7:0] d);
    @(negedge i_clk) o_byte_ack = 1'b1;
    o_wr_strobe = wr;
    o_wr_data = d;
    @(negedge i_clk) o_byte_ack = 1'b0;
    o_wr_strobe = 1'b0;
    o_wr_data = ~d;
    o_reading = 1'b0;
    o_bus_stop = 1'b1;
    @(negedge i_clk) o_bus_stop = 1'b0;
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    open_at(a, 1'b0);
    byte_close(1'b1, d);
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    open_at(a, 1'b1);
    d = i_rd_data;
    byte_close(1'b0, 8'h00);
  endtask
endmodule // rtc_bus_master_model

// ==== verification/rtc_calibration_alarm_core_tb_top.sv ====
//------------------------------------------------------------
// Purpose: Self-checking bench for the timekeeping core
// Assumes: Oscillator input at 16 clocks per period
// Notes: No full second elapses, so alarm timing is not run
//------------------------------------------------------------
`timescale 1ns/1ps

module rtc_calibration_alarm_core_tb_top;
  localparam int OSC_CLKS = 16;
  logic i_clk, i_rst, i_osc_32k, i_power_fail, i_on_battery, i_watchdog_expired;
  logic bus_start, bus_stop, ptr_load, wr_strobe, byte_ack, reading, pin_out, pin_oe;
  logic [7:0] ptr_value, wr_data, rd_data, ptr, v;
  wire pin_wire = pin_oe ? pin_out : 1'b1; // Pull-up on the shared pin
  int fail_count = 0;
  int total_checks = 0;
  int n;

  rtc_calibration_alarm_core i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_osc_32k(i_osc_32k),
    .i_power_fail(i_power_fail), .i_on_battery(i_on_battery), .i_bus_start(bus_start), .i_bus_stop(bus_stop),
    .i_ptr_load(ptr_load), .i_ptr_value(ptr_value), .i_wr_strobe(wr_strobe), .i_wr_data(wr_data),
    .i_byte_ack(byte_ack), .i_reading(reading), .i_watchdog_expired(i_watchdog_expired),
    .i_sqw_level(1'b0), .i_irq_pin_in(pin_wire), .o_rd_data(rd_data), .o_ptr(ptr),
    .o_irq_pin_out(pin_out), .o_irq_pin_oe(pin_oe));
  rtc_bus_master_model i_master (.i_clk(i_clk), .i_rd_data(rd_data), .o_bus_start(bus_start),
    .o_bus_stop(bus_stop), .o_ptr_load(ptr_load), .o_ptr_value(ptr_value), .o_wr_strobe(wr_strobe),
    .o_wr_data(wr_data), .o_byte_ack(byte_ack), .o_reading(reading));

  // System clock and free running time base
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    i_osc_32k = 1'b0;
    forever #80 i_osc_32k = ~i_osc_32k;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_master.write_reg(a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string name);
    i_master.read_reg(a, v);
    check(name, {8'h00, v}, {8'h00, exp});
  endtask

  // Bounded wait for the pin enable, a timeout ends the run
  task automatic wait_oe(input logic lvl, input int lim);
    for (n = 0; n < lim && pin_oe !== lvl; n++) @(negedge i_clk);
    check("pin_oe", {15'h0000, pin_oe}, {15'h0000, lvl});
    if (n >= lim) end_of_test;
  endtask

  // One full half period of the test output in clocks
  task automatic test_half;
    wait_oe(1'b0, 1200);
    wait_oe(1'b1, 1200);
    for (n = 0; n < 1200 && pin_oe !== 1'b0; n++) @(negedge i_clk);
    check("test_half", 16'(n), 16'(rtc_core_pkg::FT_HALF_TICKS * OSC_CLKS));
    if (n >= 1200) end_of_test;
  endtask

  initial begin
    i_rst = 1'b1;
    i_power_fail = 1'b0;
    i_on_battery = 1'b0;
    i_watchdog_expired = 1'b0;
    repeat (20) @(negedge i_clk);
    i_rst = 1'b0;
    rchk(8'h01, 8'h80, "seconds");
    rchk(8'h0c, 8'h40, "alarm_hour");
    rchk(8'h08, 8'h80, "control");
    rchk(8'h14, 8'h00, "unmapped");
    wr(8'h0f, 8'hff);
    rchk(8'h0f, 8'h00, "flags_write");
    wr(8'h11, 8'ha5);
    rchk(8'h11, 8'h00, "reserved");
    wr(8'h08, 8'h25);
    rchk(8'h08, 8'h25, "calibration");
    wait_oe(1'b1, 20);
    wr(8'h08, 8'h80);
    wait_oe(1'b0, 20);
    wr(8'h0a, 8'h40);
    wait_oe(1'b1, 20);
    wr(8'h0a, 8'h00);
    wait_oe(1'b0, 20);
    wr(8'h09, 8'h0e);
    @(negedge i_clk) i_watchdog_expired = 1'b1;
    @(negedge i_clk) i_watchdog_expired = 1'b0;
    wait_oe(1'b1, 20);
    rchk(8'h0f, 8'h80, "flags_set");
    wait_oe(1'b0, 20);
    rchk(8'h0f, 8'h00, "flags_clear");
    wr(8'h09, 8'h00);
    wr(8'h0c, 8'h00);
    wr(8'h01, 8'h00);
    wr(8'h08, 8'hc0);
    test_half;
    wr(8'h08, 8'hff);
    test_half;
    repeat (6000) @(negedge i_clk);
    wr(8'h02, 8'h00);
    rchk(8'h00, 8'h00, "fraction_reset");
    repeat (6000) @(negedge i_clk);
    i_power_fail = 1'b1;
    repeat (20) @(negedge i_clk);
    i_power_fail = 1'b0;
    rchk(8'h0c, 8'h40, "freeze_set");
    rchk(8'h08, 8'hbf, "test_bit_clear");
    repeat (6000) @(negedge i_clk);
    rchk(8'h00, 8'h01, "frozen");
    wr(8'h0c, 8'h00);
    repeat (6000) @(negedge i_clk);
    rchk(8'h00, 8'h03, "thawed");
    wr(8'h08, 8'h00);
    wait_oe(1'b1, 20);
    i_on_battery = 1'b1;
    wait_oe(1'b0, 50);
    i_on_battery = 1'b0;
    wait_oe(1'b1, 50);
    end_of_test;
  end
endmodule // rtc_calibration_alarm_core_tb_top
